//--- rtl/fps_clk_div.sv
/*
 File: counter divider that emits one single-cycle tick every N input
 ticks, used for the output divider and for the reference predivider.
 Assumes: ticks arrive as single-cycle enables on the core clock.
*/
`timescale 1ns/1ps
module fps_clk_div
   import fps_pkg::*;
#(
   parameter int W = 8
)
(
   input wire logic core_clk_in,
   input wire logic rst_in,
   input wire logic tick_in,
   input wire logic [W-1:0] div_in,
   output logic tick_out
);

   logic [W-1:0] cnt_reg;
   logic [W-1:0] half;

   // Divide by zero or one passes every tick; larger divides count full periods.
   assign half = (div_in > 1) ? div_in : {{(W-1){1'b0}}, 1'b1};

   // Counter wraps and emits one tick per full divide period.
   always_ff @(posedge core_clk_in)
   begin
      if (rst_in)
      begin
         cnt_reg <= '0;
         tick_out <= 1'b0;
      end
      else
      begin
         tick_out <= 1'b0;
         if (tick_in)
         begin
            if (cnt_reg >= half - 1'b1)
            begin
               cnt_reg <= '0;
               tick_out <= 1'b1;
            end
            else
               cnt_reg <= cnt_reg + 1'b1;
         end
      end
   end

endmodule

//--- rtl/fps_pkg.sv
/*
 File: shared constants and carrier types for the fractional PLL
 configuration sequencer.
 Assumes: included before every design module of the block.
*/
package fps_pkg;

   // ==================================================================
   // Register map of the plain software port.
   // ==================================================================
   localparam int FPS_AW = 4;
   localparam logic [3:0] FPS_OFF_CTRL = 4'h0;
   localparam logic [3:0] FPS_OFF_PREDIV = 4'h1;
   localparam logic [3:0] FPS_OFF_DIVOUT = 4'h2;
   localparam logic [3:0] FPS_OFF_INT = 4'h3;
   localparam logic [3:0] FPS_OFF_FRAC0 = 4'h4;
   localparam logic [3:0] FPS_OFF_FRAC1 = 4'h5;
   localparam logic [3:0] FPS_OFF_FRAC2 = 4'h6;
   localparam logic [3:0] FPS_OFF_MODE = 4'h7;
   localparam logic [3:0] FPS_OFF_CAL = 4'h8;
   localparam logic [3:0] FPS_OFF_STATUS = 4'h9;

   // Control register bit positions.
   localparam int FPS_BIT_START = 0;
   localparam int FPS_BIT_SRC = 1;
   localparam int FPS_BIT_REFSEL = 2;

   // Status register bit positions.
   localparam int FPS_BIT_LOCKED = 0;
   localparam int FPS_BIT_USING_PLL = 1;
   localparam int FPS_BIT_POWERED = 2;

   // ==================================================================
   // Field encodings and reset values.
   // ==================================================================
   localparam logic [1:0] FPS_PREDIV_1 = 2'h0;
   localparam logic [1:0] FPS_PREDIV_2 = 2'h1;
   localparam logic [1:0] FPS_PREDIV_4 = 2'h2;
   localparam logic [1:0] FPS_PREDIV_8 = 2'h3;
   localparam logic [1:0] FPS_MODE_BYPASS = 2'h3;
   localparam logic [7:0] FPS_DIVOUT_RST = 8'h10;
   localparam logic [7:0] FPS_INT_RST = 8'h40;
   localparam logic [7:0] FPS_CAL_RST = 8'h80;
   localparam logic [1:0] FPS_MODE_RST = 2'h3;

   // ==================================================================
   // Timing: settling time before the output is released.
   // ==================================================================
   localparam int FPS_CLK_MHZ = 125;
   localparam int FPS_SETTLE_US = 800;
   localparam int FPS_SETTLE_CYC = FPS_SETTLE_US * FPS_CLK_MHZ;

   // Frequency settings handed to the analog PLL macro.
   typedef struct packed {
      logic [1:0] predivider;
      logic [7:0] int_factor;
      logic [23:0] frac_factor;
      logic [1:0] mode;
      logic [7:0] output_divider;
      logic [7:0] cal_ratio;
   } fps_pll_cfg_t;

   typedef enum logic [1:0] {
      FPS_OFF,
      FPS_SETTLING,
      FPS_RUNNING
   } fps_state_t;

endpackage

//--- rtl/fps_pll_seq.sv
/*
 File: top of the fractional PLL configuration sequencer: software
 registers, reference selection, start and settle sequencing, and the
 glitch-free choice between bypass and PLL master clock.
 Assumes: the PLL loop itself is an analog macro fed from pll_cfg_out;
 this logic sees its output as pll_clk_tick_in, one pulse per VCO
 edge modelled on the core clock, and software honours the power-up
 order and calibration arithmetic.
*/
// Our own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps

// Function
// - Source select zero bypasses PLL; reference drives master clock directly.
// - Master clock equals reference over predivider times factor over divisors.
// - Mode value binary 11 bypasses both scaling factors.
// - Predivider codes 0, 2 and 3 divide by 1, 4 and 8.
// - Output divider field holds the divide count directly.
// - Reference comes from the shared serial or two-wire clock pin.
// - Start bit clear powers down; set powers up with current settings.
module fps_pll_seq
   import fps_pkg::*;
#(
   parameter int SETTLE_CYC = FPS_SETTLE_CYC
)
(
   input wire logic core_clk_in,
   input wire logic rst_in,
   input wire logic [FPS_AW-1:0] addr_in,
   input wire logic [7:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [7:0] rdata_out,
   input wire logic serial_port_bit_clock_in,
   input wire logic two_wire_link_clock_in,
   input wire logic pll_clk_tick_in,
   output logic pll_power_up_out,
   output fps_pll_cfg_t pll_cfg_out,
   output logic mclk_tick_out,
   output logic ref_tick_out,
   output logic pll_settled_out
);

   // ==================================================================
   // Software registers.
   // ==================================================================
   logic start_reg;
   logic master_clock_source_select_reg;
   logic ref_sel_reg;
   logic [1:0] reference_predivider_reg;
   logic [7:0] pll_output_divider_reg;
   logic [7:0] int_reg;
   logic [23:0] frac_reg;
   logic [1:0] mode_reg;
   logic [7:0] cal_reg;
   fps_state_t state_reg;
   fps_state_t state_next;
   logic [16:0] settle_cnt_reg;
   logic use_pll_reg;
   logic [7:0] rd_next;

   // Writes take effect on the edge that samples the strobe.
   always_ff @(posedge core_clk_in)
   begin
      if (rst_in)
      begin
         start_reg <= 1'b0;
         master_clock_source_select_reg <= 1'b0;
         ref_sel_reg <= 1'b0;
         reference_predivider_reg <= FPS_PREDIV_1;
         pll_output_divider_reg <= FPS_DIVOUT_RST;
         int_reg <= FPS_INT_RST;
         frac_reg <= '0;
         mode_reg <= FPS_MODE_RST;
         cal_reg <= FPS_CAL_RST;
      end
      else if (wr_in)
      begin
         case (addr_in)
            FPS_OFF_CTRL:
            begin
               start_reg <= wdata_in[FPS_BIT_START];
               master_clock_source_select_reg <= wdata_in[FPS_BIT_SRC];
               ref_sel_reg <= wdata_in[FPS_BIT_REFSEL];
            end
            FPS_OFF_PREDIV: reference_predivider_reg <= wdata_in[1:0];
            FPS_OFF_DIVOUT: pll_output_divider_reg <= wdata_in;
            FPS_OFF_INT: int_reg <= wdata_in;
            FPS_OFF_FRAC0: frac_reg[7:0] <= wdata_in;
            FPS_OFF_FRAC1: frac_reg[15:8] <= wdata_in;
            FPS_OFF_FRAC2: frac_reg[23:16] <= wdata_in;
            FPS_OFF_MODE: mode_reg <= wdata_in[1:0];
            FPS_OFF_CAL: cal_reg <= wdata_in;
            default: ;
         endcase
      end
   end

   // Read mux; unmapped addresses read zero.
   always_comb
   begin
      rd_next = '0;
      case (addr_in)
         FPS_OFF_CTRL:
         begin
            rd_next[FPS_BIT_START] = start_reg;
            rd_next[FPS_BIT_SRC] = master_clock_source_select_reg;
            rd_next[FPS_BIT_REFSEL] = ref_sel_reg;
         end
         FPS_OFF_PREDIV: rd_next[1:0] = reference_predivider_reg;
         FPS_OFF_DIVOUT: rd_next = pll_output_divider_reg;
         FPS_OFF_INT: rd_next = int_reg;
         FPS_OFF_FRAC0: rd_next = frac_reg[7:0];
         FPS_OFF_FRAC1: rd_next = frac_reg[15:8];
         FPS_OFF_FRAC2: rd_next = frac_reg[23:16];
         FPS_OFF_MODE: rd_next[1:0] = mode_reg;
         FPS_OFF_CAL: rd_next = cal_reg;
         FPS_OFF_STATUS:
         begin
            rd_next[FPS_BIT_LOCKED] = (state_reg == FPS_RUNNING);
            rd_next[FPS_BIT_USING_PLL] = use_pll_reg;
            rd_next[FPS_BIT_POWERED] = pll_power_up_out;
         end
         default: rd_next = '0;
      endcase
   end

   // Read data stand only in the cycle after the strobe.
   always_ff @(posedge core_clk_in)
   begin
      if (rst_in)
         rdata_out <= '0;
      else if (rd_in)
         rdata_out <= rd_next;
      else
         rdata_out <= '0;
   end

   // ==================================================================
   // Reference selection and predivision.
   // ==================================================================
   logic sbc_sync;
   logic twc_sync;
   logic ref_lvl_reg;
   logic ref_rise;
   logic [3:0] prediv_count;

   // Both candidate pins pass through synchronisers before use.
   fps_sync2 u_sync_sbc
   (
      .core_clk_in(core_clk_in),
      .rst_in(rst_in),
      .d_in(serial_port_bit_clock_in),
      .q_out(sbc_sync)
   );

   fps_sync2 u_sync_twc
   (
      .core_clk_in(core_clk_in),
      .rst_in(rst_in),
      .d_in(two_wire_link_clock_in),
      .q_out(twc_sync)
   );

   // The shared pin: one of the two link clocks becomes the reference.
   always_ff @(posedge core_clk_in)
   begin
      if (rst_in)
         ref_lvl_reg <= 1'b0;
      else
         ref_lvl_reg <= ref_sel_reg ? twc_sync : sbc_sync;
   end

   assign ref_rise = (ref_sel_reg ? twc_sync : sbc_sync) & ~ref_lvl_reg;

   // Predivider decode; code 1 is not documented and divides by two.
   always_comb
   begin
      case (reference_predivider_reg)
         FPS_PREDIV_1: prediv_count = 4'h1;
         FPS_PREDIV_2: prediv_count = 4'h2;
         FPS_PREDIV_4: prediv_count = 4'h4;
         FPS_PREDIV_8: prediv_count = 4'h8;
         default: prediv_count = 4'h1;
      endcase
   end

   logic ref_div_tick;

   // The divided reference is what the PLL phase detector compares.
   fps_clk_div #(.W(4)) u_prediv
   (
      .core_clk_in(core_clk_in),
      .rst_in(rst_in),
      .tick_in(ref_rise),
      .div_in(prediv_count),
      .tick_out(ref_div_tick)
   );

   always_ff @(posedge core_clk_in)
   begin
      if (rst_in)
         ref_tick_out <= 1'b0;
      else
         ref_tick_out <= ref_div_tick;
   end

   // ==================================================================
   // Settings to the analog loop; mode 11 selects no scaling.
   // ==================================================================
   always_ff @(posedge core_clk_in)
   begin
      if (rst_in)
      begin
         pll_cfg_out <= '0;
         pll_power_up_out <= 1'b0;
      end
      else
      begin
         pll_cfg_out.predivider <= reference_predivider_reg;
         pll_cfg_out.int_factor <= int_reg;
         pll_cfg_out.frac_factor <= frac_reg;
         pll_cfg_out.mode <= mode_reg;
         pll_cfg_out.output_divider <= pll_output_divider_reg;
         pll_cfg_out.cal_ratio <= cal_reg;
         pll_power_up_out <= start_reg;
      end
   end

   // ==================================================================
   // Start and settle sequencing.
   // ==================================================================
   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         FPS_OFF:
            if (start_reg)
               state_next = FPS_SETTLING;
         FPS_SETTLING:
            if (!start_reg)
               state_next = FPS_OFF;
            else if (settle_cnt_reg == 17'(SETTLE_CYC - 1))
               state_next = FPS_RUNNING;
         FPS_RUNNING:
            if (!start_reg)
               state_next = FPS_OFF;
         default: state_next = FPS_OFF;
      endcase
   end

   always_ff @(posedge core_clk_in)
   begin
      if (rst_in)
         state_reg <= FPS_OFF;
      else
         state_reg <= state_next;
   end

   // Settle counter runs only while settling, so each start restarts it.
   always_ff @(posedge core_clk_in)
   begin
      if (rst_in)
         settle_cnt_reg <= '0;
      else if (state_reg == FPS_SETTLING)
         settle_cnt_reg <= settle_cnt_reg + 1'b1;
      else
         settle_cnt_reg <= '0;
   end

   always_ff @(posedge core_clk_in)
   begin
      if (rst_in)
         pll_settled_out <= 1'b0;
      else
         pll_settled_out <= (state_next == FPS_RUNNING);
   end

   // ==================================================================
   // Output divider and glitch-free source switch.
   // ==================================================================
   logic pll_div_tick;

   fps_clk_div #(.W(8)) u_outdiv
   (
      .core_clk_in(core_clk_in),
      .rst_in(rst_in),
      .tick_in(pll_clk_tick_in),
      .div_in(pll_output_divider_reg),
      .tick_out(pll_div_tick)
   );

   // The source changes only between ticks, so no runt period escapes;
   // PLL is chosen only once it is running.
   always_ff @(posedge core_clk_in)
   begin
      if (rst_in)
         use_pll_reg <= 1'b0;
      else if (!ref_rise && !pll_div_tick)
         use_pll_reg <= master_clock_source_select_reg
            && (state_reg == FPS_RUNNING);
   end

   // Bypass passes the raw reference; an unsettled PLL stays quiet.
   always_ff @(posedge core_clk_in)
   begin
      if (rst_in)
         mclk_tick_out <= 1'b0;
      else if (!master_clock_source_select_reg && !use_pll_reg)
         mclk_tick_out <= ref_rise;
      else if (use_pll_reg)
         mclk_tick_out <= pll_div_tick;
      else
         mclk_tick_out <= 1'b0;
   end

   // ==================================================================
   // Checks.
   // ==================================================================
   sequence s_start_rise;
      !start_reg ##1 start_reg;
   endsequence

   chk_settle_quiet: assert property (
      @(posedge core_clk_in) disable iff (rst_in)
      (state_reg == FPS_SETTLING) |-> !use_pll_reg)
      else $error("PLL selected before settling ended");

   chk_start_settle: assert property (
      @(posedge core_clk_in) disable iff (rst_in)
      s_start_rise |=> (state_reg == FPS_SETTLING))
      else $error("Start did not begin settling");

   chk_stop_power: assert property (
      @(posedge core_clk_in) disable iff (rst_in)
      !start_reg |=> !pll_power_up_out && (state_reg == FPS_OFF))
      else $error("PLL not powered down after start cleared");

   chk_bypass_path: assert property (
      @(posedge core_clk_in) disable iff (rst_in)
      (!master_clock_source_select_reg && !use_pll_reg)
      |=> (mclk_tick_out == $past(ref_rise)))
      else $error("Bypass clock does not follow reference");

   chk_pll_path: assert property (
      @(posedge core_clk_in) disable iff (rst_in)
      use_pll_reg |=> (mclk_tick_out == $past(pll_div_tick)))
      else $error("Master clock does not follow divided PLL");

   chk_mode_pass: assert property (
      @(posedge core_clk_in) disable iff (rst_in)
      (mode_reg == FPS_MODE_BYPASS) |=> (pll_cfg_out.mode == FPS_MODE_BYPASS))
      else $error("Mode bypass not passed to the loop");

   chk_prediv_8: assert property (
      @(posedge core_clk_in) disable iff (rst_in)
      (reference_predivider_reg == FPS_PREDIV_8) |-> (prediv_count == 4'h8))
      else $error("Predivider code 11 not divide by 8");

   chk_divout_wr: assert property (
      @(posedge core_clk_in) disable iff (rst_in)
      (wr_in && addr_in == FPS_OFF_DIVOUT) |=> ##1
      (pll_cfg_out.output_divider == $past(wdata_in, 2)))
      else $error("Output divider value not held directly");

   chk_ref_pick: assert property (
      @(posedge core_clk_in) disable iff (rst_in)
      $stable(ref_sel_reg) |=> (ref_lvl_reg == $past(ref_sel_reg ? twc_sync
      : sbc_sync)))
      else $error("Reference not taken from selected pin");

endmodule

//--- rtl/fps_sync2.sv
/*
 File: two flip-flop level synchroniser for the reference pin.
 Assumes: the input may change at any time relative to core_clk_in.
*/
`timescale 1ns/1ps
module fps_sync2
   import fps_pkg::*;
(
   input wire logic core_clk_in,
   input wire logic rst_in,
   input wire logic d_in,
   output logic q_out
);

   logic meta_reg;

   // The first stage is read only by the second stage.
   always_ff @(posedge core_clk_in)
   begin
      if (rst_in)
      begin
         meta_reg <= 1'b0;
         q_out <= 1'b0;
      end
      else
      begin
         meta_reg <= d_in;
         q_out <= meta_reg;
      end
   end

endmodule

//--- tb/test_fps_pll_seq.sv
/*
 File: self-checking bench for the PLL configuration sequencer top.
 Assumes: the package and design files are compiled first; the bench
 plays software, the reference pins and the analog loop itself.
*/
`timescale 1ns/1ps
module test_fps_pll_seq import fps_pkg::*;;
   localparam int SETTLE = 20;
   logic core_clk;
   logic rst;
   logic [FPS_AW-1:0] addr;
   logic [7:0] wdata;
   logic wr;
   logic rd;
   logic [7:0] rdata;
   logic ser_ref;
   logic tw_ref;
   logic pll_tick;
   logic pll_run;
   logic power_up;
   fps_pll_cfg_t cfg;
   logic mclk_tick;
   logic ref_tick;
   logic settled;
   int fail_count = 0;
   int samples_checked = 0;
   int mclk_cnt = 0;
   int ref_cnt = 0;
   int cyc = 0;

   fps_pll_seq #(.SETTLE_CYC(SETTLE)) i_fps_pll_seq (
      .core_clk_in(core_clk), .rst_in(rst), .addr_in(addr),
      .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
      .serial_port_bit_clock_in(ser_ref),
      .two_wire_link_clock_in(tw_ref), .pll_clk_tick_in(pll_tick),
      .pll_power_up_out(power_up), .pll_cfg_out(cfg),
      .mclk_tick_out(mclk_tick), .ref_tick_out(ref_tick),
      .pll_settled_out(settled));

   // ==================================================================
   // Clock, loop model and monitors.
   // ==================================================================
   // Core clock at 125 MHz.
   initial
   begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end

   // The loop model pulses every other cycle while it runs.
   always @(posedge core_clk)
      pll_tick <= pll_run & ~pll_tick;

   // Tick counters; tests use differences so no one resets them.
   always @(posedge core_clk)
   begin
      if (mclk_tick === 1'b1)
         mclk_cnt <= mclk_cnt + 1;
      if (ref_tick === 1'b1)
         ref_cnt <= ref_cnt + 1;
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         fail_count++;
         results();
      end
   end

   // ==================================================================
   // Shared tasks.
   // ==================================================================
   task automatic check_val(input logic [23:0] got, exp, string what);
      samples_checked++;
      if (got !== exp)
      begin
         $display("unexpected at %0t: %s got %0h exp %0h", $time, what,
            got, exp);
         fail_count++;
      end
   endtask

   task automatic check_range(input int got, lo, hi, string what);
      samples_checked++;
      if (got < lo || got > hi)
      begin
         $display("unexpected at %0t: %s got %0d", $time, what, got);
         fail_count++;
      end
   endtask

   task automatic bus_wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge core_clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge core_clk);
      wr <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe.
   task automatic rd_chk(input logic [3:0] a, input logic [7:0] m, e,
      string what);
      @(posedge core_clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge core_clk);
      rd <= 1'b0;
      #1;
      check_val({16'h0, rdata & m}, {16'h0, e}, what);
   endtask

   // Slow reference edges so the two-stage synchroniser sees each one.
   task automatic ref_edges(input bit on_two_wire, input int n);
      repeat (n)
      begin
         repeat (4) @(posedge core_clk);
         if (on_two_wire) tw_ref <= 1'b1;
         else ser_ref <= 1'b1;
         repeat (4) @(posedge core_clk);
         tw_ref <= 1'b0;
         ser_ref <= 1'b0;
      end
      repeat (6) @(posedge core_clk);
   endtask

   task automatic results();
      $display("checked %0d, mismatches %0d", samples_checked,
         fail_count);
      if (fail_count == 0 && samples_checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // ==================================================================
   // Scenarios.
   // ==================================================================
   task automatic test_reset();
      logic [3:0] offs [10] = '{FPS_OFF_CTRL, FPS_OFF_DIVOUT, FPS_OFF_INT,
         FPS_OFF_FRAC0, FPS_OFF_FRAC1, FPS_OFF_FRAC2, FPS_OFF_MODE,
         FPS_OFF_CAL, FPS_OFF_STATUS, 4'hA};
      logic [7:0] vals [10] = '{8'h00, 8'h10, 8'h40, 8'h00, 8'h00, 8'h00,
         8'h03, 8'h80, 8'h00, 8'h00};
      for (int i = 0; i < 10; i++)
         rd_chk(offs[i], 8'hFF, vals[i], "reset value");
      check_val({23'h0, power_up}, 24'h0, "power after reset");
      check_val({23'h0, settled}, 24'h0, "settled after reset");
      $display("test reset done");
   endtask

   // Writes one idle cycle apart, then every mode code in turn.
   task automatic test_fields();
      bus_wr(FPS_OFF_PREDIV, 8'h03);
      bus_wr(FPS_OFF_DIVOUT, 8'h08);
      bus_wr(FPS_OFF_INT, 8'h50);
      bus_wr(FPS_OFF_FRAC0, 8'h34);
      bus_wr(FPS_OFF_FRAC1, 8'h11);
      bus_wr(FPS_OFF_FRAC2, 8'h36);
      bus_wr(FPS_OFF_CAL, 8'h6B);
      bus_wr(4'hB, 8'h55);
      repeat (2) @(posedge core_clk);
      #1;
      check_val({22'h0, cfg.predivider}, 24'h3, "predivider");
      check_val({16'h0, cfg.output_divider}, 24'h8, "divout");
      check_val({16'h0, cfg.int_factor}, 24'h50, "int");
      check_val(cfg.frac_factor, 24'h361134, "frac");
      check_val({16'h0, cfg.cal_ratio}, 24'h6B, "cal");
      for (int m = 0; m < 4; m++)
      begin
         bus_wr(FPS_OFF_MODE, 8'(m));
         repeat (2) @(posedge core_clk);
         #1;
         check_val({22'h0, cfg.mode}, 24'(m), "mode");
         rd_chk(FPS_OFF_MODE, 8'h03, 8'(m), "mode read");
      end
      $display("test fields done");
   endtask

   // Predivider codes 0, 2 and 3 over 32 edges each, bypass, then pin choice.
   task automatic test_reference();
      logic [1:0] codes [3] = '{FPS_PREDIV_1, FPS_PREDIV_4, FPS_PREDIV_8};
      int divs [3] = '{1, 4, 8};
      int r0;
      int m0;
      bus_wr(FPS_OFF_CTRL, 8'h00);
      for (int i = 0; i < 3; i++)
      begin
         bus_wr(FPS_OFF_PREDIV, {6'h0, codes[i]});
         r0 = ref_cnt;
         m0 = mclk_cnt;
         ref_edges(1'b0, 32);
         check_range(ref_cnt - r0, 32 / divs[i] - 1, 32 / divs[i] + 1,
            "predivided ticks");
         if (i == 0)
            check_range(mclk_cnt - m0, 31, 33, "bypass ticks");
      end
      // Back to divide by one so each two-wire edge gives one tick.
      bus_wr(FPS_OFF_PREDIV, {6'h0, FPS_PREDIV_1});
      bus_wr(FPS_OFF_CTRL, 8'h04);
      r0 = ref_cnt;
      ref_edges(1'b0, 8);
      check_range(ref_cnt - r0, 0, 0, "deselected pin");
      ref_edges(1'b1, 8);
      check_range(ref_cnt - r0, 7, 9, "two-wire pin");
      $display("test reference done");
   endtask

   // Start, quiet settle, divided output, divider rewrite, stop.
   task automatic test_start();
      int m0;
      int n;
      // Software plays the documented power-up order with n of two.
      bus_wr(FPS_OFF_PREDIV, {6'h0, FPS_PREDIV_1});
      bus_wr(FPS_OFF_DIVOUT, 8'h10);
      bus_wr(FPS_OFF_FRAC0, 8'h00);
      bus_wr(FPS_OFF_FRAC1, 8'h00);
      bus_wr(FPS_OFF_FRAC2, 8'h00);
      bus_wr(FPS_OFF_INT, 8'h40);
      bus_wr(FPS_OFF_MODE, 8'h03);
      bus_wr(FPS_OFF_CAL, 8'h80);
      pll_run <= 1'b1;
      bus_wr(FPS_OFF_CTRL, 8'h03);
      m0 = mclk_cnt;
      n = 0;
      while (settled !== 1'b1 && n < 200)
      begin
         @(posedge core_clk);
         #1;
         n++;
      end
      check_range(n, SETTLE - 2, SETTLE + 4, "settle time");
      check_range(mclk_cnt - m0, 0, 1, "quiet while settling");
      check_val({23'h0, power_up}, 24'h1, "powered");
      m0 = mclk_cnt;
      repeat (128) @(posedge core_clk);
      check_range(mclk_cnt - m0, 3, 5, "divide by 16");
      rd_chk(FPS_OFF_STATUS, 8'h07, 8'h07, "status running");
      bus_wr(FPS_OFF_DIVOUT, 8'h08);
      repeat (4) @(posedge core_clk);
      m0 = mclk_cnt;
      repeat (128) @(posedge core_clk);
      check_range(mclk_cnt - m0, 7, 9, "divide by 8");
      bus_wr(FPS_OFF_CTRL, 8'h02);
      repeat (3) @(posedge core_clk);
      #1;
      check_val({23'h0, power_up}, 24'h0, "powered down");
      check_val({23'h0, settled}, 24'h0, "not settled");
      rd_chk(FPS_OFF_STATUS, 8'h05, 8'h00, "status stopped");
      pll_run <= 1'b0;
      $display("test start done");
   endtask

   // Main sequence: reset for 16 cycles, then the scenarios.
   initial
   begin
      rst = 1'b1;
      addr = '0;
      wdata = '0;
      wr = 1'b0;
      rd = 1'b0;
      ser_ref = 1'b0;
      tw_ref = 1'b0;
      pll_run = 1'b0;
      repeat (16) @(posedge core_clk);
      rst <= 1'b0;
      test_reset();
      test_fields();
      test_reference();
      test_start();
      results();
   end
endmodule
